// ### rtl/dcc_pkg.sv
// constants and types shared by the converter control block
// Summary of operation
// - without auto-trigger a fresh data write starts that channel's conversion
// - with auto-trigger an event starts conversion only if unconverted data waits
// - data registers accept writes from software and from the DMA controller
// - dual mode drives two outputs, each with own data and conversion control
// - internal analog route carries the direct converter output, not a held output
// - conversion interval and refresh are counted in peripheral clock cycles
// - low-power bit 1 of first control powers the converter down between conversions
// - one 7-bit gain and one 7-bit offset calibration value are provided
// - sample codes are 12 bits; 0xFFF means full reference output
// - bit 4 of first control routes output to comparator and ADC muxes
// - bit 3 of first control puts channel 1 on its pin
// - bit 2 of first control puts channel 0 on its pin
// - bit 0 of first control enables the whole converter
// - bits 6:5 of second control: 00 single channel 0, 10 dual, others reserved
// - channel 1 auto-trigger bit 1: event starts channel 1 after high byte write
// - channel 0 auto-trigger bit 0: event starts channel 0 after high byte write
// - reference bits 4:3: 00 internal 1.00 V, 01 analog supply, 10 external pin
// - left-align bit takes both samples left-aligned in their 16-bit pair
// - three-bit event field picks one of eight event channels
// - default alignment is right: low 8 bits low byte, top 4 bits high byte
// - each channel has a data-empty flag; its registered DMA request is gated by enable, channel 1's also by dual mode
package dcc_pkg;
  // register offsets
  localparam logic [3:0] ADDR_ENABLE_CTRL  = 4'h0;
  localparam logic [3:0] ADDR_MODE_CTRL    = 4'h1;
  localparam logic [3:0] ADDR_REF_ALIGN    = 4'h2;
  localparam logic [3:0] ADDR_EVENT_CTRL   = 4'h3;
  localparam logic [3:0] ADDR_TIMING_CTRL  = 4'h4;
  localparam logic [3:0] ADDR_STATUS       = 4'h5;
  localparam logic [3:0] ADDR_GAIN_CAL     = 4'h8;
  localparam logic [3:0] ADDR_OFFSET_CAL   = 4'h9;
  localparam logic [3:0] ADDR_CH0_LOW      = 4'hC;
  localparam logic [3:0] ADDR_CH0_HIGH     = 4'hD;
  localparam logic [3:0] ADDR_CH1_LOW      = 4'hE;
  localparam logic [3:0] ADDR_CH1_HIGH     = 4'hF;
  // writable bit masks (reserved bits read zero)
  localparam logic [7:0] MASK_ENABLE_CTRL  = 8'h1F;
  localparam logic [7:0] MASK_MODE_CTRL    = 8'h63;
  localparam logic [7:0] MASK_REF_ALIGN    = 8'h19;
  localparam logic [7:0] MASK_EVENT_CTRL   = 8'h07;
  localparam logic [7:0] MASK_TIMING_CTRL  = 8'h7F;
  localparam logic [7:0] MASK_CAL          = 8'h7F;
  localparam logic [7:0] RESET_BYTE        = 8'h00;
  localparam logic [7:0] RESET_TIMING      = 8'h0F;
  // field positions
  localparam int BIT_ENABLE     = 0;
  localparam int BIT_LOW_POWER  = 1;
  localparam int BIT_PIN0       = 2;
  localparam int BIT_PIN1       = 3;
  localparam int BIT_INTERNAL   = 4;
  localparam int BIT_TRIG0      = 0;
  localparam int BIT_TRIG1      = 1;
  localparam int POS_CHAN_CFG   = 5;
  localparam int POS_REF_SOURCE = 3;
  localparam int BIT_LEFT_ALIGN = 0;
  localparam int POS_INTERVAL   = 4;
  // channel configuration codes
  localparam logic [1:0] CFG_SINGLE   = 2'b00;
  localparam logic [1:0] CFG_DUAL     = 2'b10;
  // refresh code that switches auto refresh off, and top legal code
  localparam logic [3:0] REFRESH_OFF  = 4'hF;
  localparam logic [3:0] REFRESH_MAX  = 4'hC;
  // base refresh is 16 cycles (shift of 4)
  localparam int REFRESH_BASE_SHIFT   = 4;
  // extra settling cycles after a power-down in low-power mode
  localparam int WAKE_TIME_NS         = 1000;
  localparam int CLK_PERIOD_NS        = 25;
  localparam logic [7:0] WAKE_CYCLES  = 8'((WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int SAMPLE_W             = 12;
  typedef enum logic [1:0] {DCC_IDLE, DCC_WAKE, DCC_CONVERT} dcc_state_t;
endpackage

// ### rtl/dcc_chan_if.sv
// per-channel data and handshake bundle between main block and channel holder
`timescale 1ns/1ps
`default_nettype none
interface dcc_chan_if;
  logic        wr_low;   // low byte write
  logic        wr_high;  // high byte write
  logic [7:0]  wdata;
  logic        left;     // left-align select
  logic        taken;    // conversion took the pending sample
  logic [11:0] sample;
  logic        pending;  // unconverted data waits
  logic        empty;    // data register empty
  modport owner  (output wr_low, wr_high, wdata, left, taken,
                  input sample, pending, empty);
  modport holder (input wr_low, wr_high, wdata, left, taken,
                  output sample, pending, empty);
endinterface
`default_nettype wire

// ### rtl/dcc_chan.sv
// one channel's data register pair, alignment and empty flag
`timescale 1ns/1ps
`default_nettype none
module dcc_chan (
  input wire logic ref_clk,
  input wire logic rst_n,
  dcc_chan_if.holder ch
);
  import dcc_pkg::*;
  logic [7:0] low_byte;
  logic [7:0] high_byte;

  // byte storage, written by software or DMA alike
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      low_byte  <= RESET_BYTE;
      high_byte <= RESET_BYTE;
    end else begin
      if (ch.wr_low) low_byte <= ch.wdata;
      if (ch.wr_high) high_byte <= ch.wdata;
    end
  end

  // a high byte write commits the sample; set beats the clear of a conversion
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ch.pending <= 1'b0;
    end else if (ch.wr_high) begin
      ch.pending <= 1'b1;
    end else if (ch.taken) begin
      ch.pending <= 1'b0;
    end
  end

  assign ch.empty = ~ch.pending;
  // right aligned by default, left aligned on request
  assign ch.sample = ch.left ? {high_byte, low_byte[7:4]}
                             : {high_byte[3:0], low_byte};
endmodule
`default_nettype wire

// ### rtl/dcc_top.sv
// converter control: registers, trigger logic, sequencing and output controls
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module dcc_top (
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  input  wire logic [3:0]                  addr,
  input  wire logic [7:0]                  wdata,
  input  wire logic                        wr_en,
  input  wire logic                        rd_en,
  output var  logic [7:0]                  rdata,
  input  wire logic [7:0]                  event_in,
  output var  logic [1:0]                  dma_req,
  output var  logic [dcc_pkg::SAMPLE_W-1:0] conv_code,
  output var  logic                        conv_start,
  output var  logic                        conv_busy,
  output var  logic                        conv_power,
  output var  logic [1:0]                  hold_load,
  output var  logic [1:0]                  pin_enable,
  output var  logic                        internal_route,
  output var  logic [1:0]                  ref_select,
  output var  logic [6:0]                  gain_trim,
  output var  logic [6:0]                  offset_trim
);
  import dcc_pkg::*;

  logic [7:0] enable_ctrl;
  logic [7:0] mode_ctrl;
  logic [7:0] ref_align;
  logic [7:0] event_ctrl;
  logic [7:0] timing_ctrl;
  logic [7:0] gain_cal;
  logic [7:0] offset_cal;
  logic [7:0] event_meta;
  logic [7:0] event_sync;
  logic       event_hit;
  logic       is_dual;
  dcc_state_t state;
  logic [7:0] wait_cnt;
  logic [7:0] interval_len;
  logic [16:0] refresh_cnt;
  logic [16:0] refresh_len;
  logic       refresh_due;
  logic [1:0] refresh_req;
  logic       cur_ch;
  logic       last_ch;
  logic [1:0] start_ok;
  logic       pick;
  logic       go;
  logic       powered;

  dcc_chan_if ch0 ();
  dcc_chan_if ch1 ();

  dcc_chan u_ch0 (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ch      (ch0.holder)
  );
  dcc_chan u_ch1 (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ch      (ch1.holder)
  );

  // write decode into each channel
  assign ch0.wr_low  = wr_en && (addr == ADDR_CH0_LOW);
  assign ch0.wr_high = wr_en && (addr == ADDR_CH0_HIGH);
  assign ch1.wr_low  = wr_en && (addr == ADDR_CH1_LOW);
  assign ch1.wr_high = wr_en && (addr == ADDR_CH1_HIGH);
  assign ch0.wdata   = wdata;
  assign ch1.wdata   = wdata;
  assign ch0.left    = ref_align[BIT_LEFT_ALIGN];
  assign ch1.left    = ref_align[BIT_LEFT_ALIGN];
  assign ch0.taken   = go && !pick && start_ok[0];
  assign ch1.taken   = go && pick && start_ok[1];

  // control registers; reserved bits are masked off on write
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      enable_ctrl <= RESET_BYTE;
      mode_ctrl   <= RESET_BYTE;
      ref_align   <= RESET_BYTE;
      event_ctrl  <= RESET_BYTE;
      timing_ctrl <= RESET_TIMING;
      gain_cal    <= RESET_BYTE;
      offset_cal  <= RESET_BYTE;
    end else if (wr_en) begin
      unique case (addr)
        ADDR_ENABLE_CTRL: enable_ctrl <= wdata & MASK_ENABLE_CTRL;
        ADDR_MODE_CTRL:   mode_ctrl   <= wdata & MASK_MODE_CTRL;
        ADDR_REF_ALIGN:   ref_align   <= wdata & MASK_REF_ALIGN;
        ADDR_EVENT_CTRL:  event_ctrl  <= wdata & MASK_EVENT_CTRL;
        ADDR_TIMING_CTRL: timing_ctrl <= wdata & MASK_TIMING_CTRL;
        ADDR_GAIN_CAL:    gain_cal    <= wdata & MASK_CAL;
        ADDR_OFFSET_CAL:  offset_cal  <= wdata & MASK_CAL;
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe, zero otherwise and when unmapped
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata <= RESET_BYTE;
    end else if (rd_en) begin
      unique case (addr)
        ADDR_ENABLE_CTRL: rdata <= enable_ctrl;
        ADDR_MODE_CTRL:   rdata <= mode_ctrl;
        ADDR_REF_ALIGN:   rdata <= ref_align;
        ADDR_EVENT_CTRL:  rdata <= event_ctrl;
        ADDR_TIMING_CTRL: rdata <= timing_ctrl;
        ADDR_STATUS:      rdata <= {6'h00, ch1.empty, ch0.empty};
        ADDR_GAIN_CAL:    rdata <= gain_cal;
        ADDR_OFFSET_CAL:  rdata <= offset_cal;
        default:          rdata <= RESET_BYTE;
      endcase
    end else begin
      rdata <= RESET_BYTE;
    end
  end

  // event lines come from outside this clock, two flops first
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      event_meta <= RESET_BYTE;
      event_sync <= RESET_BYTE;
    end else begin
      event_meta <= event_in;
      event_sync <= event_meta;
    end
  end
  assign event_hit = event_sync[event_ctrl[2:0]];

  // dual channel only for the documented code; reserved codes act as single
  assign is_dual = (mode_ctrl[POS_CHAN_CFG +: 2] == CFG_DUAL);

  // conversion interval in clock cycles, 50% longer in dual mode for codes above 0
  function automatic logic [7:0] interval_cycles(input logic [2:0] code, input logic dual);
    logic [7:0] base;
    base = 8'(1) << code;
    interval_cycles = (dual && code != 3'd0) ? 8'(base + (base >> 1)) : base;
  endfunction
  assign interval_len = interval_cycles(timing_ctrl[POS_INTERVAL +: 3], is_dual);
  assign refresh_len  = 17'(1) << (REFRESH_BASE_SHIFT + 32'(timing_ctrl[3:0]));

  // which channel may start now
  always_comb begin
    start_ok[0] = ch0.pending && (!mode_ctrl[BIT_TRIG0] || event_hit);
    start_ok[1] = is_dual && ch1.pending
                  && (!mode_ctrl[BIT_TRIG1] || event_hit);
    if (refresh_req[0]) start_ok[0] = 1'b1;
    if (refresh_req[1] && is_dual) start_ok[1] = 1'b1;
  end
  // alternate between channels when both are ready
  assign pick = (start_ok == 2'b11) ? !last_ch : start_ok[1];
  assign go   = enable_ctrl[BIT_ENABLE] && (state == DCC_IDLE) && (start_ok != 2'b00);

  // refresh timer marks both held outputs for an update
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      refresh_cnt <= '0;
      refresh_req <= 2'b00;
    end else if (!is_dual || !enable_ctrl[BIT_ENABLE]
                 || timing_ctrl[3:0] == REFRESH_OFF || timing_ctrl[3:0] > REFRESH_MAX) begin
      refresh_cnt <= '0;
      refresh_req <= 2'b00;
    end else begin
      refresh_cnt <= refresh_due ? '0 : refresh_cnt + 17'd1;
      refresh_req[0] <= refresh_due | (refresh_req[0] & ~(go & ~pick));
      refresh_req[1] <= refresh_due | (refresh_req[1] & ~(go & pick));
    end
  end
  assign refresh_due = (refresh_cnt == refresh_len - 17'd1);

  // sequencer: optional wake-up, then the conversion interval
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state    <= DCC_IDLE;
      wait_cnt <= '0;
      cur_ch   <= 1'b0;
      last_ch  <= 1'b0;
    end else if (!enable_ctrl[BIT_ENABLE]) begin
      state    <= DCC_IDLE;
      wait_cnt <= '0;
    end else begin
      unique case (state)
        DCC_IDLE: begin
          if (go) begin
            cur_ch  <= pick;
            last_ch <= pick;
            if (!powered) begin
              state    <= DCC_WAKE;
              wait_cnt <= WAKE_CYCLES - 8'd1;
            end else begin
              state    <= DCC_CONVERT;
              wait_cnt <= interval_len - 8'd1;
            end
          end
        end
        DCC_WAKE: begin
          if (wait_cnt == 8'd0) begin
            state    <= DCC_CONVERT;
            wait_cnt <= interval_len - 8'd1;
          end else begin
            wait_cnt <= wait_cnt - 8'd1;
          end
        end
        DCC_CONVERT: begin
          if (wait_cnt == 8'd0) state <= DCC_IDLE;
          else wait_cnt <= wait_cnt - 8'd1;
        end
      endcase
    end
  end
  // converter is powered only while enabled, and low-power mode lets it drop while idle
  assign powered = !enable_ctrl[BIT_LOW_POWER] && conv_power;

  // registered outputs toward the analog stage
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      conv_code  <= '0;
      conv_start <= 1'b0;
      conv_busy  <= 1'b0;
      conv_power <= 1'b0;
      hold_load  <= 2'b00;
    end else begin
      conv_start <= go;
      conv_busy  <= go || (state != DCC_IDLE && !(state == DCC_CONVERT && wait_cnt == 8'd0));
      conv_power <= enable_ctrl[BIT_ENABLE]
                    && (!enable_ctrl[BIT_LOW_POWER] || go || state != DCC_IDLE);
      if (go) conv_code <= pick ? ch1.sample : ch0.sample;
      // held outputs load at the end of the interval, direct output is conv_code
      hold_load <= (is_dual && state == DCC_CONVERT && wait_cnt == 8'd0)
                   ? (cur_ch ? 2'b10 : 2'b01) : 2'b00;
    end
  end

  // static controls and request lines
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dma_req        <= 2'b00;
      pin_enable     <= 2'b00;
      internal_route <= 1'b0;
      ref_select     <= 2'b00;
      gain_trim      <= '0;
      offset_trim    <= '0;
    end else begin
      dma_req        <= {ch1.empty & is_dual, ch0.empty} & {2{enable_ctrl[BIT_ENABLE]}};
      pin_enable[0]  <= enable_ctrl[BIT_ENABLE] & enable_ctrl[BIT_PIN0];
      pin_enable[1]  <= enable_ctrl[BIT_ENABLE] & enable_ctrl[BIT_PIN1];
      internal_route <= enable_ctrl[BIT_ENABLE] & enable_ctrl[BIT_INTERNAL];
      ref_select     <= ref_align[POS_REF_SOURCE +: 2];
      gain_trim      <= gain_cal[6:0];
      offset_trim    <= offset_cal[6:0];
    end
  end

  // checks
  property p_start_needs_enable;
    @(posedge ref_clk) disable iff (!rst_n) conv_start |-> $past(enable_ctrl[BIT_ENABLE]);
  endproperty
  a_start_needs_enable: assert property (p_start_needs_enable) else $error("start while off");

  property p_auto_start;
    @(posedge ref_clk) disable iff (!rst_n)
      (enable_ctrl[BIT_ENABLE] && !mode_ctrl[BIT_TRIG0] && !is_dual && state == DCC_IDLE
       && ch0.pending) |=> conv_start;
  endproperty
  a_auto_start: assert property (p_auto_start) else $error("no start on fresh data");

  property p_trig_waits;
    @(posedge ref_clk) disable iff (!rst_n)
      (mode_ctrl[BIT_TRIG0] && !is_dual && !event_hit) |=> !conv_start;
  endproperty
  a_trig_waits: assert property (p_trig_waits) else $error("start without event");

  property p_write_sets_pending;
    @(posedge ref_clk) disable iff (!rst_n) ch0.wr_high |=> ch0.pending;
  endproperty
  a_write_sets_pending: assert property (p_write_sets_pending) else $error("pending lost");

  property p_single_no_ch1;
    @(posedge ref_clk) disable iff (!rst_n) !is_dual |-> !ch1.taken;
  endproperty
  a_single_no_ch1: assert property (p_single_no_ch1) else $error("ch1 in single");

  property p_dma_follows_empty;
    @(posedge ref_clk) disable iff (!rst_n)
      enable_ctrl[BIT_ENABLE] |=> dma_req[0] == $past(ch0.empty);
  endproperty
  a_dma_follows_empty: assert property (p_dma_follows_empty) else $error("dma mismatch");

  property p_pin0;
    @(posedge ref_clk) disable iff (!rst_n)
      ##1 pin_enable[0] == $past(enable_ctrl[BIT_ENABLE] & enable_ctrl[BIT_PIN0]);
  endproperty
  a_pin0: assert property (p_pin0) else $error("pin 0 enable wrong");

  property p_low_power_off;
    @(posedge ref_clk) disable iff (!rst_n)
      (enable_ctrl[BIT_LOW_POWER] && state == DCC_IDLE && !go) ##1 enable_ctrl[BIT_LOW_POWER]
      |-> !conv_power;
  endproperty
  a_low_power_off: assert property (p_low_power_off) else $error("powered while idle");

  property p_off_no_start;
    @(posedge ref_clk) disable iff (!rst_n) !enable_ctrl[BIT_ENABLE] |=> !conv_start;
  endproperty
  a_off_no_start: assert property (p_off_no_start) else $error("start while disabled");

  property p_single_pulse;
    @(posedge ref_clk) disable iff (!rst_n) conv_start |=> !conv_start;
  endproperty
  a_single_pulse: assert property (p_single_pulse) else $error("start held");

  property p_hold_dual_only;
    @(posedge ref_clk) disable iff (!rst_n) (hold_load != 2'b00) |-> $past(is_dual);
  endproperty
  a_hold_dual_only: assert property (p_hold_dual_only) else $error("load in single");

  property p_internal_route;
    @(posedge ref_clk) disable iff (!rst_n)
      ##1 internal_route == $past(enable_ctrl[BIT_ENABLE] & enable_ctrl[BIT_INTERNAL]);
  endproperty
  a_internal_route: assert property (p_internal_route) else $error("route wrong");

  property p_wake_entry;
    @(posedge ref_clk) disable iff (!rst_n)
      (go && !powered) |=> (state == DCC_WAKE && wait_cnt == WAKE_CYCLES - 8'd1);
  endproperty
  a_wake_entry: assert property (p_wake_entry) else $error("no wake-up");

  property p_code_loaded;
    @(posedge ref_clk) disable iff (!rst_n) (go && !pick) |=> conv_code == $past(ch0.sample);
  endproperty
  a_code_loaded: assert property (p_code_loaded) else $error("wrong code");

  c_dual_load: cover property (@(posedge ref_clk) disable iff (!rst_n) hold_load == 2'b10);
  c_event_start: cover property (@(posedge ref_clk) disable iff (!rst_n)
                                 mode_ctrl[BIT_TRIG0] ##1 conv_start);
  c_wake: cover property (@(posedge ref_clk) disable iff (!rst_n) state == DCC_WAKE);
  c_refresh: cover property (@(posedge ref_clk) disable iff (!rst_n) refresh_due && is_dual);
  c_left_start: cover property (@(posedge ref_clk) disable iff (!rst_n) go && ch0.left);
endmodule
`default_nettype wire

// ### bench/dcc_analog_model.sv
// behavioural model of the analog outputs and the internal analog consumers
`timescale 1ns/1ps
`default_nettype none
module dcc_analog_model (
  input  wire logic        ref_clk,
  input  wire logic        conv_start,
  input  wire logic [11:0] conv_code,
  input  wire logic [1:0]  hold_load,
  input  wire logic        internal_route,
  output var  logic [11:0] direct_level,
  output var  logic [11:0] held0,
  output var  logic [11:0] held1,
  output var  logic [11:0] cmp_input
);
  // direct output follows each launched code; held outputs load on their pulse
  always @(posedge ref_clk) begin
    if (conv_start) direct_level <= conv_code;
    if (hold_load[0]) held0 <= conv_code;
    if (hold_load[1]) held1 <= conv_code;
  end
  // comparator and adc muxes only ever see the direct output
  assign cmp_input = internal_route ? direct_level : 12'h000;
endmodule
`default_nettype wire

// ### bench/dcc_top_bench.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module dcc_top_bench;
  import dcc_pkg::*;
  logic        ref_clk, rst_n, wr_en, rd_en, conv_start, conv_busy, conv_power, internal_route;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata, event_in;
  logic [1:0]  dma_req, hold_load, pin_enable, ref_select;
  logic [11:0] conv_code, direct_level, held0, held1, cmp_input;
  logic [6:0]  gain_trim, offset_trim;
  int          n_mismatch, tests_run, cyc;
  dcc_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .event_in(event_in), .dma_req(dma_req),
    .conv_code(conv_code), .conv_start(conv_start), .conv_busy(conv_busy),
    .conv_power(conv_power), .hold_load(hold_load), .pin_enable(pin_enable),
    .internal_route(internal_route), .ref_select(ref_select), .gain_trim(gain_trim),
    .offset_trim(offset_trim));
  dcc_analog_model model (.ref_clk(ref_clk), .conv_start(conv_start), .conv_code(conv_code),
    .hold_load(hold_load), .internal_route(internal_route), .direct_level(direct_level),
    .held0(held0), .held1(held1), .cmp_input(cmp_input));
  // 40 MHz clock
  initial ref_clk = 1'b0;
  always #12.5 ref_clk = ~ref_clk;
  // cycle ceiling against hangs
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("summary: %0d compares, %0d mismatches", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // register bus: one-cycle strobes, read data in the following cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic put(input bit ch, input logic [7:0] hi, input logic [7:0] lo);
    wr(ch ? ADDR_CH1_LOW : ADDR_CH0_LOW, lo);
    wr(ch ? ADDR_CH1_HIGH : ADDR_CH0_HIGH, hi);
  endtask
  // counts cycles until a conversion launch, up to a limit
  task automatic wait_start(input int lim, output int n, output bit seen);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (conv_start !== 1'b1 && n < lim);
    seen = (conv_start === 1'b1);
  endtask
  task automatic idle();
    for (int i = 0; i < 400 && conv_busy !== 1'b0; i++) @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic t_regs();
    logic [3:0] ra [8] = '{ADDR_ENABLE_CTRL, ADDR_MODE_CTRL, ADDR_REF_ALIGN, ADDR_EVENT_CTRL,
      ADDR_TIMING_CTRL, ADDR_GAIN_CAL, ADDR_OFFSET_CAL, 4'h6};
    logic [7:0] rm [8] = '{MASK_ENABLE_CTRL, MASK_MODE_CTRL, MASK_REF_ALIGN, MASK_EVENT_CTRL,
      MASK_TIMING_CTRL, MASK_CAL, MASK_CAL, 8'h00};
    logic [7:0] pc [5] = '{8'h0C, 8'h0D, 8'h15, 8'h05, 8'h09};
    logic [2:0] pe [5] = '{3'h0, 3'h3, 3'h5, 3'h1, 3'h2};
    logic [7:0] d, rv;
    for (int i = 0; i < 8; i++) begin
      rv = (ra[i] == ADDR_TIMING_CTRL) ? RESET_TIMING : RESET_BYTE;
      rd(ra[i], d);
      chk(16'(d), 16'(rv), "reset value");
      wr(ra[i], 8'hFF);
      rd(ra[i], d);
      chk(16'(d), 16'(rm[i]), "reserved bits");
      wr(ra[i], rv);
    end
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_REF_ALIGN, 8'(i << 3));
      repeat (2) @(posedge ref_clk);
      chk(16'(ref_select), 16'(i), "reference code");
    end
    wr(ADDR_GAIN_CAL, 8'h55);
    wr(ADDR_OFFSET_CAL, 8'h2A);
    repeat (2) @(posedge ref_clk);
    chk(16'({gain_trim, offset_trim}), 16'({7'h55, 7'h2A}), "trim values");
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_ENABLE_CTRL, pc[i]);
      repeat (2) @(posedge ref_clk);
      chk(16'({internal_route, pin_enable}), 16'(pe[i]), "output enables");
    end
    rd(ADDR_STATUS, d);
    chk(16'(d), 16'h0003, "status empty");
    chk(16'(dma_req), 16'h0001, "dma request single");
    $display("done: registers");
  endtask
  task automatic t_direct();
    logic [7:0] hi [4] = '{8'h0A, 8'h0F, 8'hA5, 8'hFF};
    logic [7:0] lo [4] = '{8'hBC, 8'hFF, 8'hC0, 8'hF0};
    int n;
    bit s;
    logic [15:0] e;
    wr(ADDR_ENABLE_CTRL, 8'h11);
    wr(ADDR_TIMING_CTRL, 8'h6F);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_REF_ALIGN, 8'(i / 2));
      put(0, hi[i], lo[i]);
      wait_start(8, n, s);
      chk(16'(n), 16'h0002, "start latency");
      e = (i < 2) ? 16'({hi[i][3:0], lo[i]}) : 16'({hi[i], lo[i][7:4]});
      chk(16'(conv_code), e, "converted code");
      @(posedge ref_clk);
      chk(16'(cmp_input), e, "internal route");
      idle();
    end
    wr(ADDR_REF_ALIGN, 8'h00);
    $display("done: direct start");
  endtask
  task automatic t_event();
    int n;
    bit s;
    wr(ADDR_MODE_CTRL, 8'h01);
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_EVENT_CTRL, 8'(k));
      put(0, 8'h03, 8'(k));
      wait_start(8, n, s);
      chk(16'(s), 16'h0000, "no start without event");
      event_in <= 8'(1 << ((k + 1) % 8));
      wait_start(8, n, s);
      chk(16'(s), 16'h0000, "other event channel");
      event_in <= 8'(1 << k);
      wait_start(10, n, s);
      event_in <= 8'h00;
      chk(16'(s), 16'h0001, "selected event starts");
      chk(16'(conv_code), 16'({4'h3, 8'(k)}), "triggered code");
      idle();
    end
    event_in <= 8'h80;
    wait_start(10, n, s);
    event_in <= 8'h00;
    chk(16'(s), 16'h0000, "event with nothing pending");
    $display("done: event trigger");
  endtask
  task automatic t_dual();
    logic [11:0] q[$];
    int gap, last;
    wr(ADDR_TIMING_CTRL, 8'h6F);
    wr(ADDR_MODE_CTRL, 8'h42);
    repeat (3) @(posedge ref_clk);
    chk(16'(dma_req), 16'h0003, "dma request dual");
    put(1, 8'h04, 8'h56);
    put(0, 8'h01, 8'h23);
    event_in <= 8'h80;
    gap = 999;
    last = -999;
    for (int i = 0; i < 250; i++) begin
      @(posedge ref_clk);
      #1 if (conv_start === 1'b1) begin
        q.push_back(conv_code);
        gap = (i - last < gap) ? i - last : gap;
        last = i;
      end
    end
    @(posedge ref_clk) event_in <= 8'h00;
    chk(16'(q.size()), 16'h0002, "two conversions");
    chk(16'(gap >= 96), 16'h0001, "dual interval");
    chk(16'({held0 == 12'h123, held1 == 12'h456}), 16'h0003, "held outputs");
    wr(ADDR_MODE_CTRL, 8'h40);
    wr(ADDR_TIMING_CTRL, 8'h60);
    q.delete();
    for (int i = 0; i < 600; i++) begin
      @(posedge ref_clk);
      #1 if (conv_start === 1'b1) q.push_back(conv_code);
    end
    chk(16'(q.size() >= 5), 16'h0001, "refresh conversions");
    chk(16'(q.size() > 1 && q[0] != q[1]), 16'h0001, "refresh alternates");
    wr(ADDR_TIMING_CTRL, 8'h6F);
    wr(ADDR_MODE_CTRL, 8'h00);
    idle();
    $display("done: dual channel");
  endtask
  task automatic t_refuse();
    int n, nb;
    bit s;
    wr(ADDR_ENABLE_CTRL, 8'h03);
    put(0, 8'h07, 8'h77);
    wait_start(80, n, s);
    nb = 0;
    for (int i = 0; i < 400 && conv_busy !== 1'b0; i++) begin
      @(posedge ref_clk);
      #1 nb++;
    end
    repeat (3) @(posedge ref_clk);
    chk(16'(s && nb + n >= 64 + int'(WAKE_CYCLES)), 16'h0001, "low power conversion");
    chk(16'(conv_power), 16'h0000, "powered down when idle");
    wr(ADDR_ENABLE_CTRL, 8'h01);
    put(1, 8'h01, 8'h11);
    wait_start(20, n, s);
    chk(16'(s), 16'h0000, "channel 1 in single mode");
    wr(ADDR_ENABLE_CTRL, 8'h00);
    put(0, 8'h02, 8'h22);
    wait_start(20, n, s);
    chk(16'(s), 16'h0000, "disabled converter");
    $display("done: refusals and low power");
  endtask
  // main sequence
  initial begin
    rst_n = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    event_in = 8'h00;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs();
    t_direct();
    t_event();
    t_dual();
    t_refuse();
    end_of_test();
  end
endmodule
`default_nettype wire
